// >>> hdl/rpmi_pkg.sv
package rpmi_pkg;

  // Core clock and interface clock rates, in kHz.
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int LINK_1000_KHZ = 125000;
  localparam int LINK_100_KHZ = 25000;
  localparam int LINK_10_KHZ = 2500;

  // Half periods of the receive clock in core cycles, at least one cycle.
  localparam int HALF_RAW_1000 = CLK_FREQ_KHZ / (2 * LINK_1000_KHZ);
  localparam int HALF_RAW_100 = CLK_FREQ_KHZ / (2 * LINK_100_KHZ);
  localparam int HALF_RAW_10 = CLK_FREQ_KHZ / (2 * LINK_10_KHZ);
  localparam int HALF_W = 5;
  localparam logic [HALF_W-1:0] HALF_1000 =
    HALF_W'((HALF_RAW_1000 < 1) ? 1 : HALF_RAW_1000);
  localparam logic [HALF_W-1:0] HALF_100 =
    HALF_W'((HALF_RAW_100 < 1) ? 1 : HALF_RAW_100);
  localparam logic [HALF_W-1:0] HALF_10 =
    HALF_W'((HALF_RAW_10 < 1) ? 1 : HALF_RAW_10);
  localparam logic [HALF_W-1:0] HALF_LAST = 5'h01;

  // Speed codes used in the speed field, the straps and the status.
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Media channel enables per speed.
  localparam logic [3:0] CHANNELS_GIGABIT = 4'hF;
  localparam logic [3:0] CHANNELS_FAST = 4'h3;

  // Register map.
  localparam logic [15:0] ADDR_TIMING_MODE = 16'h0032;
  localparam logic [15:0] ADDR_CLOCK_DELAY = 16'h0086;
  localparam logic [15:0] ADDR_SPEED_CONTROL = 16'h0010;
  localparam logic [15:0] ADDR_LINK_STATUS = 16'h0011;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  // Field positions.
  localparam int MODE_RX_SHIFT_BIT = 0;
  localparam int MODE_TX_SHIFT_BIT = 1;
  localparam int DELAY_RX_LSB = 0;
  localparam int DELAY_TX_LSB = 4;
  localparam int SKEW_W = 4;
  localparam int SPEED_LSB = 0;
  localparam int FORCE_BIT = 2;
  localparam int REG_SOURCE_BIT = 3;

  // Skew step and number of settings per path.
  localparam int SKEW_STEP_PS = 250;
  localparam int SKEW_SETTINGS = 16;
  localparam logic [SKEW_W-1:0] SKEW_NONE = 4'h0;

  // One byte of a frame with its control indications.
  typedef struct packed {
    logic [7:0] data;
    logic valid_data;
    logic error;
  } rpmi_word_type;

  localparam int WORD_W = $bits(rpmi_word_type);
  localparam rpmi_word_type WORD_IDLE = '0;

  // Sampled transmit pins: clock, control, data.
  typedef struct packed {
    logic clock;
    logic control;
    logic [3:0] data;
  } rpmi_tx_pins_type;

endpackage

// >>> hdl/rpmi_pair_buffer.sv
`timescale 1ns/100ps
`default_nettype none

// Small FIFO with registered ready so that the source sees no comb path.
module rpmi_pair_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] in_data, // Word offered.
  input wire logic in_valid, // Word offered is valid.
  output logic in_ready, // Room for a word, registered.
  output logic [WIDTH-1:0] out_data, // Oldest word.
  output logic out_valid, // Oldest word present.
  input wire logic out_ready // Drain takes the oldest word.
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W:0] COUNT_ONE = (PTR_W + 1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic [PTR_W:0] next_count;
  logic push;
  logic pop;

  // Handshakes on both sides.
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Occupancy after this cycle.
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + COUNT_ONE;
    end else if (pop && !push) begin
      next_count = count - COUNT_ONE;
    end
  end

  // Storage is written only on a push, so it needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != COUNT_FULL);
    end
  end

endmodule

`default_nettype wire

// >>> hdl/rpmi_core.sv
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Four media channels at gigabit, two otherwise.
// - Speed forced or negotiated, from register or straps.
// - Interface clocks 125, 25, 2.5 MHz; receive clock made is 62.5, 31.25, 2.5 MHz.
// - Active high; low nibble rising, high falling.
// - Control line carries two indications per cycle.
// - Device sends valid, then valid xor error.
// - Receive control high in frames, low idle.
// - Independent transmit and receive skew, 16 settings.
// - Aligned adds none; shift in quarter-ns steps.
// - At 10/100 MAC sources tx, device rx clock.
// - Receive clock phases may stretch on changes.
// - No clock glitches while changing speed.
// - Slower speeds repeat the nibble on falling edge.
module rpmi_core
  import rpmi_pkg::*;
(
  input wire logic clk, // Core clock, 125 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [15:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_write, // Write strobe.
  input wire logic reg_read, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, cycle after strobe.
  input wire logic [1:0] strap_speed, // Strapped speed code.
  input wire logic strap_force, // Strap: force instead of negotiate.
  input wire logic [1:0] negotiated_speed, // Speed from negotiation.
  input wire logic gigabit_transmit_clock, // MAC transmit clock pin.
  input wire logic [3:0] tx_data_pin, // MAC transmit data pins.
  input wire logic tx_control_pin, // MAC transmit control pin.
  output logic rx_clock_pin, // Receive clock to the MAC.
  output logic [3:0] rx_data_pin, // Receive data to the MAC.
  output logic rx_control_pin, // Receive control to the MAC.
  input wire rpmi_word_type rx_word_in, // Received byte from media side.
  input wire logic rx_word_in_valid, // Received byte is offered.
  output logic rx_word_in_ready, // Buffer can take a byte.
  output rpmi_word_type tx_word_out, // Byte decoded from the MAC.
  output logic tx_word_out_valid, // One-cycle pulse per byte.
  output logic [3:0] tx_skew_code, // Transmit clock delay setting.
  output logic [3:0] rx_skew_code, // Receive clock delay setting.
  output logic [3:0] media_channels, // Media channel enables.
  output logic [1:0] active_speed // Speed in use.
);

  logic [15:0] timing_mode;
  logic [15:0] clock_delay;
  logic [15:0] speed_control;
  logic strap_taken;
  logic [1:0] strap_speed_q;
  logic strap_force_q;
  logic [1:0] forced_speed;
  logic forcing;
  logic [1:0] next_speed;
  logic gigabit;
  logic tx_clock_seen;
  rpmi_tx_pins_type tx_sync1;
  rpmi_tx_pins_type tx_sync2;
  rpmi_tx_pins_type tx_sync3;
  logic tx_rise;
  logic tx_fall;
  logic [3:0] tx_low_nibble;
  logic [3:0] tx_high_nibble;
  logic tx_enable_q;
  logic tx_second_half;
  logic tx_first_error;
  logic tx_error_now;
  logic [HALF_W-1:0] half_count;
  logic [HALF_W-1:0] half_load;
  logic rx_toggle;
  logic rx_rise;
  logic rx_fall;
  logic rx_second_nibble;
  rpmi_word_type rx_current;
  rpmi_word_type buf_word;
  logic buf_valid;
  logic buf_pop;

  // Register writes; all three reset to REG_RESET, skew codes follow a cycle later.
  always_ff @(posedge clk) begin
    if (rst) begin
      timing_mode <= REG_RESET;
      clock_delay <= REG_RESET;
      speed_control <= REG_RESET;
    end else if (reg_write) begin
      if (reg_addr == ADDR_TIMING_MODE) begin
        timing_mode <= reg_wdata;
      end
      if (reg_addr == ADDR_CLOCK_DELAY) begin
        clock_delay <= reg_wdata;
      end
      if (reg_addr == ADDR_SPEED_CONTROL) begin
        speed_control <= reg_wdata;
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= READ_IDLE;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_TIMING_MODE: reg_rdata <= timing_mode;
        ADDR_CLOCK_DELAY: reg_rdata <= clock_delay;
        ADDR_SPEED_CONTROL: reg_rdata <= speed_control;
        ADDR_LINK_STATUS: begin
          reg_rdata <= {4'h0, media_channels, 3'h0,
                        rx_current.valid_data, tx_clock_seen,
                        forcing, active_speed};
        end
        default: reg_rdata <= READ_IDLE;
      endcase
    end else begin
      reg_rdata <= READ_IDLE;
    end
  end

  // Straps are caught once, on the first edge after reset is released.
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_taken <= 1'b0;
      strap_speed_q <= SPEED_10;
      strap_force_q <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_speed_q <= strap_speed;
      strap_force_q <= strap_force;
    end
  end

  // Speed choice: register or strap source, forced or negotiated.
  always_comb begin
    if (speed_control[REG_SOURCE_BIT]) begin
      forced_speed = speed_control[SPEED_LSB +: 2];
      forcing = speed_control[FORCE_BIT];
    end else begin
      forced_speed = strap_speed_q;
      forcing = strap_force_q;
    end
    next_speed = forcing ? forced_speed : negotiated_speed;
  end

  assign gigabit = (active_speed == SPEED_1000);

  // Speed, channel use and skew codes, all from flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      active_speed <= SPEED_10;
      media_channels <= CHANNELS_FAST;
      tx_skew_code <= SKEW_NONE;
      rx_skew_code <= SKEW_NONE;
    end else begin
      active_speed <= next_speed;
      if (next_speed == SPEED_1000) begin
        media_channels <= CHANNELS_GIGABIT;
      end else begin
        media_channels <= CHANNELS_FAST;
      end
      // Aligned mode forces the code to zero; each step is a quarter ns.
      tx_skew_code <= timing_mode[MODE_TX_SHIFT_BIT] ?
        clock_delay[DELAY_TX_LSB +: SKEW_W] : SKEW_NONE;
      rx_skew_code <= timing_mode[MODE_RX_SHIFT_BIT] ?
        clock_delay[DELAY_RX_LSB +: SKEW_W] : SKEW_NONE;
    end
  end

  // Two-flop synchroniser for the MAC pins; stage one feeds stage two only.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sync1 <= '0;
      tx_sync2 <= '0;
      tx_sync3 <= '0;
    end else begin
      tx_sync1 <= {gigabit_transmit_clock, tx_control_pin, tx_data_pin};
      tx_sync2 <= tx_sync1;
      tx_sync3 <= tx_sync2;
    end
  end

  // Clock and data share the same latency, so edges keep their data.
  assign tx_rise = tx_sync2.clock && !tx_sync3.clock;
  assign tx_fall = !tx_sync2.clock && tx_sync3.clock;
  assign tx_error_now = tx_enable_q ^ tx_sync2.control;

  // The MAC keeps the clock low until speeds match; an edge shows it runs.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_clock_seen <= 1'b0;
    end else if (tx_rise) begin
      tx_clock_seen <= 1'b1;
    end else if (next_speed != active_speed) begin
      tx_clock_seen <= 1'b0;
    end
  end

  // Transmit decode: rising edge gives enable and a nibble, the high one on the second clock at 10/100.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_low_nibble <= 4'h0;
      tx_high_nibble <= 4'h0;
      tx_enable_q <= 1'b0;
    end else if (tx_rise) begin
      tx_enable_q <= tx_sync2.control;
      if (gigabit || !tx_second_half) begin
        tx_low_nibble <= tx_sync2.data;
      end else begin
        tx_high_nibble <= tx_sync2.data;
      end
    end
  end

  // Falling edge completes a byte; slower speeds need two clocks per byte.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_word_out <= WORD_IDLE;
      tx_word_out_valid <= 1'b0;
      tx_second_half <= 1'b0;
      tx_first_error <= 1'b0;
    end else begin
      tx_word_out_valid <= 1'b0;
      if (tx_fall) begin
        if (gigabit) begin
          tx_second_half <= 1'b0;
          if (tx_enable_q || tx_error_now) begin
            tx_word_out <= '{data: {tx_sync2.data, tx_low_nibble},
                             valid_data: tx_enable_q,
                             error: tx_error_now};
            tx_word_out_valid <= 1'b1;
          end
        end else if (!tx_second_half) begin
          // Falling-edge data repeat the rising nibble and are ignored.
          if (tx_enable_q || tx_error_now) begin
            tx_second_half <= 1'b1;
            tx_first_error <= tx_error_now;
          end
        end else begin
          tx_second_half <= 1'b0;
          tx_word_out <= '{data: {tx_high_nibble, tx_low_nibble},
                           valid_data: tx_enable_q,
                           error: tx_error_now || tx_first_error};
          tx_word_out_valid <= 1'b1;
        end
      end
    end
  end

  // Two-entry buffer so a slow receive clock loses no byte.
  rpmi_pair_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(2)
  ) u_rx_buffer (
    .clk(clk),
    .rst(rst),
    .in_data(rx_word_in),
    .in_valid(rx_word_in_valid),
    .in_ready(rx_word_in_ready),
    .out_data(buf_word),
    .out_valid(buf_valid),
    .out_ready(buf_pop)
  );

  // Half period for the current speed.
  always_comb begin
    case (active_speed)
      SPEED_1000: half_load = HALF_1000;
      SPEED_100: half_load = HALF_100;
      SPEED_10: half_load = HALF_10;
      default: half_load = HALF_10;
    endcase
  end

  assign rx_toggle = (half_count == HALF_LAST);
  assign rx_rise = rx_toggle && !rx_clock_pin;
  assign rx_fall = rx_toggle && rx_clock_pin;
  assign buf_pop = rx_rise && (gigabit || !rx_second_nibble);

  // Receive clock divider. A new speed is loaded only at a phase end,
  // so a phase may stretch but never shortens into a glitch.
  always_ff @(posedge clk) begin
    if (rst) begin
      half_count <= HALF_10;
      rx_clock_pin <= 1'b0;
    end else if (rx_toggle) begin
      half_count <= half_load;
      rx_clock_pin <= !rx_clock_pin;
    end else begin
      half_count <= half_count - HALF_LAST;
    end
  end

  // Receive drive: valid on rising, valid xor error on falling.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_current <= WORD_IDLE;
      rx_second_nibble <= 1'b0;
      rx_data_pin <= 4'h0;
      rx_control_pin <= 1'b0;
    end else if (rx_rise) begin
      if (buf_pop) begin
        // An empty buffer sends idle, which holds control low.
        rx_current <= buf_valid ? buf_word : WORD_IDLE;
        rx_data_pin <= buf_valid ? buf_word.data[3:0] : 4'h0;
        rx_control_pin <= buf_valid && buf_word.valid_data;
        rx_second_nibble <= !gigabit && buf_valid;
      end else begin
        rx_data_pin <= rx_current.data[7:4];
        rx_control_pin <= rx_current.valid_data;
        rx_second_nibble <= 1'b0;
      end
    end else if (rx_fall) begin
      if (gigabit) begin
        rx_data_pin <= rx_current.data[7:4];
      end
      rx_control_pin <= rx_current.valid_data ^ rx_current.error;
    end
  end

endmodule

`default_nettype wire

// >>> verif/rpmi_core_props.sv
`timescale 1ns/100ps
`default_nettype none
// Relations between the core's ports over time.
module rpmi_core_props
  import rpmi_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst, // Reset.
  input wire logic [15:0] reg_addr, // Address.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_write, // Write strobe.
  input wire logic reg_read, // Read strobe.
  input wire logic [15:0] reg_rdata, // Read data.
  input wire logic rx_clock_pin, // Receive clock.
  input wire logic [3:0] rx_data_pin, // Receive nibble.
  input wire logic rx_control_pin, // Receive control.
  input wire rpmi_word_type tx_word_out, // Decoded byte.
  input wire logic tx_word_out_valid, // Byte pulse.
  input wire logic [3:0] tx_skew_code, // Transmit delay.
  input wire logic [3:0] rx_skew_code, // Receive delay.
  input wire logic [3:0] media_channels, // Channel enables.
  input wire logic [1:0] active_speed // Speed in use.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Stale read data would pass for a fresh read.
  chk_read_idle: assert property (
    !reg_read |=> reg_rdata == 16'h0000) else $error("stale read data");
  chk_media_speed: assert property (
    media_channels == ((active_speed == SPEED_1000) ?
    CHANNELS_GIGABIT : CHANNELS_FAST)) else $error("channels vs speed");
  chk_ctl_with_clock: assert property (
    $changed(rx_control_pin) |-> $changed(rx_clock_pin))
    else $error("control moved off clock");
  chk_data_with_clock: assert property (
    $changed(rx_data_pin) |-> $changed(rx_clock_pin))
    else $error("data moved off clock");
  chk_tx_aligned: assert property (
    reg_write && reg_addr == ADDR_TIMING_MODE &&
    !reg_wdata[MODE_TX_SHIFT_BIT] |-> ##3 tx_skew_code == SKEW_NONE)
    else $error("tx skew in aligned mode");
  chk_rx_aligned: assert property (
    reg_write && reg_addr == ADDR_TIMING_MODE &&
    !reg_wdata[MODE_RX_SHIFT_BIT] |-> ##3 rx_skew_code == SKEW_NONE)
    else $error("rx skew in aligned mode");
  chk_byte_pulse: assert property (
    tx_word_out_valid |=> !tx_word_out_valid[*3])
    else $error("byte pulses too close");
  chk_idle_silent: assert property (
    tx_word_out_valid |-> tx_word_out.valid_data || tx_word_out.error)
    else $error("byte from idle cycle");
  // A half period shorter than the speed's count is a glitch.
  chk_clk_fast_half: assert property (
    active_speed == SPEED_100 && $stable(active_speed) &&
    $rose(rx_clock_pin) |=> rx_clock_pin ##1 !rx_clock_pin)
    else $error("bad half period at 100");
  chk_clk_gig_rate: assert property (
    active_speed == SPEED_1000 && $stable(active_speed) &&
    $changed(rx_clock_pin) |=> $changed(rx_clock_pin))
    else $error("bad gigabit clock");
  cov_err_byte: cover property (tx_word_out_valid && tx_word_out.error);
  cov_slow_clk: cover property (active_speed == SPEED_10 &&
    $rose(rx_clock_pin));
  cov_read: cover property (reg_read && reg_addr == ADDR_CLOCK_DELAY);
endmodule
bind rpmi_core rpmi_core_props rpmi_core_props_inst (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .rx_clock_pin(rx_clock_pin), .rx_data_pin(rx_data_pin),
  .rx_control_pin(rx_control_pin), .tx_word_out(tx_word_out),
  .tx_word_out_valid(tx_word_out_valid), .tx_skew_code(tx_skew_code),
  .rx_skew_code(rx_skew_code), .media_channels(media_channels),
  .active_speed(active_speed));
`default_nettype wire

// >>> verif/rpmi_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural MAC: sends bytes on its own clock, decodes receive pins.
module rpmi_mac_model
  import rpmi_pkg::*;
(
  input wire logic clk, // Core clock, samples the receive pins.
  input wire logic fast, // High at 10 or 100 Mbps.
  output logic tx_clock, // Transmit clock.
  output logic [3:0] tx_data, // Transmit nibble.
  output logic tx_control, // Transmit control.
  input wire logic rx_clock, // Receive clock.
  input wire logic [3:0] rx_data, // Receive nibble.
  input wire logic rx_control // Receive control.
);
  rpmi_word_type got[$];
  logic prev_clk = 1'b0;
  logic half = 1'b0;
  logic [3:0] lo = 4'h0;
  logic dv = 1'b0;
  // The clock rests low until a frame, as the speed may not match yet.
  initial begin
    tx_clock = 1'b0;
    tx_control = 1'b0;
    tx_data = 4'h0;
  end
  // One 32 ns phase; data moves mid-phase to stay clear of each edge.
  task automatic phase(input logic [3:0] d, input logic c);
    tx_data = d;
    tx_control = c;
    #16 tx_clock = ~tx_clock;
    #16;
  endtask
  task automatic send(input logic [7:0] b, input logic en, input logic er);
    if (fast) begin
      phase(b[3:0], en);
      phase(b[3:0], en ^ er);
      phase(b[7:4], en);
      phase(b[7:4], en ^ er);
    end else begin
      phase(b[3:0], en);
      phase(b[7:4], en ^ er);
    end
  endtask
  // Released data lines show junk, so stale values are never trusted.
  task automatic idle();
    tx_control = 1'b0;
    tx_data = ~tx_data;
  endtask
  // Pins move with the receive clock, so act on edges seen by clk.
  always @(posedge clk) begin
    prev_clk <= rx_clock;
    if (rx_clock && !prev_clk) begin
      if (!half) lo <= rx_data;
      dv <= rx_control;
    end
    if (!rx_clock && prev_clk) begin
      if (fast && !half && dv) begin
        half <= 1'b1;
      end else begin
        half <= 1'b0;
        if (dv || rx_control) got.push_back({rx_data, lo, dv,
          dv ^ rx_control});
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
// Bench for the link core against a behavioural MAC.
module tb;
  import rpmi_pkg::*;
  logic clk, rst, reg_write, reg_read, strap_force, fast;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] strap_speed, negotiated_speed, active_speed;
  logic txc, txctl, rxc, rxctl, rx_word_in_valid, rx_word_in_ready;
  logic tx_word_out_valid;
  logic [3:0] txd, rxd, tx_skew_code, rx_skew_code, media_channels;
  rpmi_word_type rx_word_in, tx_word_out;
  rpmi_word_type seen[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  // Host-side crossover control; the enable bit chosen here is arbitrary.
  localparam logic [15:0] ADDR_CROSSOVER = 16'h001E;
  localparam logic [15:0] CROSSOVER_ON = 16'h0001;
  rpmi_core rpmi_core_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .strap_speed(strap_speed),
    .strap_force(strap_force), .negotiated_speed(negotiated_speed),
    .gigabit_transmit_clock(txc), .tx_data_pin(txd),
    .tx_control_pin(txctl), .rx_clock_pin(rxc), .rx_data_pin(rxd),
    .rx_control_pin(rxctl), .rx_word_in(rx_word_in),
    .rx_word_in_valid(rx_word_in_valid),
    .rx_word_in_ready(rx_word_in_ready), .tx_word_out(tx_word_out),
    .tx_word_out_valid(tx_word_out_valid), .tx_skew_code(tx_skew_code),
    .rx_skew_code(rx_skew_code), .media_channels(media_channels),
    .active_speed(active_speed));
  rpmi_mac_model rpmi_mac_model_inst (.clk(clk), .fast(fast),
    .tx_clock(txc), .tx_data(txd), .tx_control(txctl), .rx_clock(rxc),
    .rx_data(rxd), .rx_control(rxctl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Collect decoded bytes; a hang is cut short by the cycle ceiling.
  always @(posedge clk) begin
    if (tx_word_out_valid === 1'b1) seen.push_back(tx_word_out);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    check(reg_rdata, exp);
  endtask
  task automatic set_speed(input logic [1:0] s, input logic [15:0] ctl);
    fast = (s != SPEED_1000);
    if (s == SPEED_100 && ctl[FORCE_BIT]) wr(ADDR_CROSSOVER, CROSSOVER_ON);
    wr(ADDR_SPEED_CONTROL, ctl | {14'h0000, s});
    repeat (4) @(posedge clk);
    check({14'h0000, active_speed}, {14'h0000, s});
    check({12'h000, media_channels}, fast ? 16'h0003 : 16'h000F);
  endtask
  task automatic t_regs();
    rd(ADDR_TIMING_MODE, REG_RESET);
    rd(ADDR_CLOCK_DELAY, REG_RESET);
    wr(ADDR_TIMING_MODE, 16'h0003);
    for (int i = 0; i < SKEW_SETTINGS; i++) begin
      wr(ADDR_CLOCK_DELAY, {8'h00, 4'(i), 4'(15 - i)});
      repeat (3) @(posedge clk);
      check({12'h000, tx_skew_code}, 16'(i));
      check({12'h000, rx_skew_code}, 16'(15 - i));
    end
    wr(ADDR_TIMING_MODE, 16'h0001);
    repeat (3) @(posedge clk);
    check({12'h000, tx_skew_code}, 16'h0000);
    check({12'h000, rx_skew_code}, 16'h0000);
    rd(ADDR_CLOCK_DELAY, 16'h00F0);
    // Receive path aligned while its delay field is non-zero.
    wr(ADDR_CLOCK_DELAY, 16'h00A5);
    wr(ADDR_TIMING_MODE, 16'h0002);
    repeat (3) @(posedge clk);
    check({12'h000, tx_skew_code}, 16'h000A);
    check({12'h000, rx_skew_code}, 16'h0000);
    rd(16'h0040, READ_IDLE);
    $display("test regs done");
  endtask
  task automatic t_speed();
    check({14'h0000, active_speed}, 16'h0002);
    check({12'h000, media_channels}, 16'h000F);
    set_speed(SPEED_100, 16'h000C);
    set_speed(SPEED_10, 16'h000C);
    set_speed(SPEED_100, 16'h0008);
    $display("test speed done");
  endtask
  task automatic t_tx(input logic [1:0] s);
    set_speed(s, 16'h000C);
    seen.delete();
    // The speed change cleared the clock-seen flag; no edge has come yet.
    rd(ADDR_LINK_STATUS, (s == SPEED_1000) ? 16'h0F06 : 16'h0305);
    #3;
    rpmi_mac_model_inst.send(8'h96, 1'b1, 1'b0);
    rpmi_mac_model_inst.send(8'h3C, 1'b1, 1'b1);
    rpmi_mac_model_inst.idle();
    repeat (60) @(posedge clk);
    rd(ADDR_LINK_STATUS, (s == SPEED_1000) ? 16'h0F0E : 16'h030D);
    check(16'(seen.size()), 16'h0002);
    check(16'(seen[0]), 16'({8'h96, 2'b10}));
    check(16'(seen[1]), 16'({8'h3C, 2'b11}));
    $display("test tx done");
  endtask
  task automatic t_rx(input logic [1:0] s);
    rpmi_word_type w[3] = '{'{8'h5A, 1'b1, 1'b0}, '{8'hC3, 1'b1, 1'b1},
      '{8'h0F, 1'b1, 1'b0}};
    set_speed(s, 16'h000C);
    rpmi_mac_model_inst.got.delete();
    for (int i = 0; i < 3; i++) begin
      rx_word_in <= w[i];
      rx_word_in_valid <= 1'b1;
      @(posedge clk);
      while (rx_word_in_ready !== 1'b1) @(posedge clk);
    end
    rx_word_in_valid <= 1'b0;
    for (int k = 0; k < 2000 && rpmi_mac_model_inst.got.size() < 3; k++)
      @(posedge clk);
    for (int i = 0; i < 3; i++)
      check(16'(rpmi_mac_model_inst.got[i]), 16'(w[i]));
    repeat (60) @(posedge clk);
    check({15'h0000, rxctl}, 16'h0000);
    $display("test rx done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Straps select gigabit at reset; tests then walk the speeds.
  initial begin
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    strap_speed = SPEED_1000;
    strap_force = 1'b1;
    negotiated_speed = SPEED_100;
    rx_word_in = WORD_IDLE;
    rx_word_in_valid = 1'b0;
    fast = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wr(16'h0170, 16'h0C1F);
    t_speed();
    t_regs();
    t_tx(SPEED_1000);
    t_tx(SPEED_100);
    t_rx(SPEED_1000);
    t_rx(SPEED_10);
    report_and_stop();
  end
endmodule
`default_nettype wire
